// >>> logic/hbas_pkg.sv
// Package of constants for host buffer access steering
package hbas_pkg;
  localparam int          ADDR_W       = 11;
  localparam int          DATA_W       = 16;
  localparam int          FIFO_DEPTH   = 32;
  localparam logic [3:0]  OFS_PTR_LO   = 4'hA;
  localparam logic [3:0]  OFS_PTR_HI   = 4'hB;
  localparam logic [3:0]  OFS_DATA_LO  = 4'hC;
  localparam logic [3:0]  OFS_DATA_HI  = 4'hD;
  localparam logic [10:0] PTR_RESET    = 11'h000;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;
  localparam logic [10:0] PTR_STEP     = 11'h001;
endpackage : hbas_pkg

// >>> logic/hbas_fifo.sv
// Read and write request FIFO with registered read data
module hbas_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign push     = in_valid && in_ready;
  // Pop only into a free or draining output stage, so no word is lost
  assign pop      = (cnt_q != '0) && (!out_valid || out_ready);

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= rd_q + AW'(1);
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Registered output: one word staged outside the array
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (!out_valid || out_ready) begin
      out_valid <= pop;
      if (pop) begin
        out_data <= mem_q[rd_q];
      end
    end
  end
endmodule : hbas_fifo

// >>> logic/hbas_top.sv
// Host buffer access steering: pointer, data port and byte lanes
// Notes on behaviour
// - Pointer updates whole only on low write
// - Pointer selects buffer word in I/O mode
// - Single byte data access still allowed
// - Upper data half access advances pointer
// - Byte, word, odd data accesses increment
// - 16-bit memory mode word address from A10-A1
// - A0 and byte-high enable steer lanes
// - 8-bit mode: strobes high, low lane
// - 16-bit strobe only for pointer, data
// - Data register low half at offset 12
module hbas_top #(
  parameter int ADDR_W = hbas_pkg::ADDR_W,
  parameter int DEPTH  = hbas_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // Configuration straps
  input  wire logic        mode_16bit,
  input  wire logic        mode_io,
  input  wire logic        auto_inc,
  // Host cycle, one-cycle request
  input  wire logic        io_req,
  input  wire logic        mem_req,
  input  wire logic        wr_en,
  input  wire logic [3:0]  io_offset,
  input  wire logic [10:0] bus_addr,
  input  wire logic        sbhe_n,
  input  wire logic [15:0] wdata,
  input  wire logic        io_sel,
  input  wire logic        mem_sel,
  // Host answer
  output logic [15:0]      rdata,
  output logic             rdata_valid,
  output logic             lo_oe_n,
  output logic             hi_oe_n,
  output logic             iocs16_n,
  output logic             memcs16_n,
  output logic             busy,
  // Buffer RAM port
  output logic             ram_we,
  output logic             ram_re,
  output logic [10:0]      ram_addr,
  output logic [15:0]      ram_wdata,
  output logic [1:0]       ram_be,
  input  wire logic [15:0] ram_rdata
);
  localparam int FW = 1 + 1 + ADDR_W + hbas_pkg::DATA_W + 2;

  logic [10:0] ptr_q;
  logic [7:0]  ptr_hi_q;
  logic        lo_b;
  logic        hi_b;
  logic        is_ptr;
  logic        is_data;
  logic [1:0]  be;
  logic [10:0] addr;
  logic        hit;
  logic        bump;
  logic        f_valid;
  logic        f_ready;
  logic        o_valid;
  logic [FW-1:0] o_data;
  logic        rd_pend_q;
  logic [1:0]  rd_be_q;

  // Lane decode; undefined combinations just fall through
  assign lo_b    = mode_16bit ? !bus_addr[0] : 1'b1;
  assign hi_b    = mode_16bit ? !sbhe_n : 1'b0;
  assign is_ptr  = io_req && (io_offset == hbas_pkg::OFS_PTR_LO ||
                              io_offset == hbas_pkg::OFS_PTR_HI);
  assign is_data = io_req && mode_io && (io_offset == hbas_pkg::OFS_DATA_LO ||
                              io_offset == hbas_pkg::OFS_DATA_HI);
  assign hit     = is_data || (mem_req && !mode_io);
  assign be      = {hi_b, lo_b};
  // Word address source: pointer or address lines
  always_comb begin
    addr = ptr_q;
    if (mem_req && !mode_io && mode_16bit) begin
      addr = {1'b0, bus_addr[10:1]};
    end else if (mem_req && !mode_io) begin
      addr = bus_addr;
    end
  end
  // 8-bit any data access bumps; 16-bit only if upper lane touched
  assign bump = is_data && auto_inc && (!mode_16bit || hi_b);
  assign f_valid = hit && (wr_en || (!rd_pend_q && !o_valid));

  // Pointer: high byte held until low byte lands
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ptr_q    <= hbas_pkg::PTR_RESET;
      ptr_hi_q <= hbas_pkg::BYTE_ZERO;
    end else if (is_ptr && wr_en && mode_16bit && lo_b) begin
      ptr_q <= {(hi_b ? wdata[10:8] : ptr_hi_q[2:0]), wdata[7:0]};
      // Word write refreshes the held high byte for later low writes
      if (hi_b) begin
        ptr_hi_q <= wdata[15:8];
      end
    end else if (is_ptr && wr_en && mode_16bit && hi_b) begin
      ptr_hi_q <= wdata[15:8];
    end else if (is_ptr && wr_en && io_offset == hbas_pkg::OFS_PTR_HI) begin
      ptr_hi_q <= wdata[7:0];
    end else if (is_ptr && wr_en) begin
      ptr_q <= {ptr_hi_q[2:0], wdata[7:0]};
    end else if (bump && f_valid && f_ready) begin
      ptr_q <= ptr_q + hbas_pkg::PTR_STEP;
    end
  end

  // Access queue toward the buffer; full queue shows as busy
  hbas_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .in_valid  (f_valid),
    .in_ready  (f_ready),
    .in_data   ({wr_en, 1'b1, addr, wdata, be}),
    .out_valid (o_valid),
    .out_ready (1'b1),
    .out_data  (o_data)
  );

  // RAM port driven from the queue head
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ram_we    <= 1'b0;
      ram_re    <= 1'b0;
      ram_addr  <= '0;
      ram_wdata <= '0;
      ram_be    <= '0;
      rd_pend_q <= 1'b0;
      rd_be_q   <= '0;
    end else begin
      ram_we    <= o_valid && o_data[FW-1];
      ram_re    <= o_valid && !o_data[FW-1];
      ram_addr  <= o_data[FW-3 -: ADDR_W];
      ram_wdata <= o_data[17:2];
      ram_be    <= o_data[1:0];
      if (o_valid && !o_data[FW-1]) begin
        rd_pend_q <= 1'b1;
        rd_be_q   <= o_data[1:0];
      end else if (ram_re) begin
        rd_pend_q <= 1'b0;
      end
    end
  end

  // Read return with lane steering and strobes
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdata       <= '0;
      rdata_valid <= 1'b0;
      lo_oe_n     <= 1'b1;
      hi_oe_n     <= 1'b1;
      iocs16_n    <= 1'b1;
      memcs16_n   <= 1'b1;
      busy        <= 1'b0;
    end else begin
      busy        <= !f_ready || rd_pend_q;
      rdata_valid <= ram_re;
      lo_oe_n     <= !(ram_re && rd_be_q[0]);
      hi_oe_n     <= !(ram_re && rd_be_q[1]);
      if (ram_re) begin
        rdata <= ram_rdata;
      end else if (io_req && !wr_en && is_ptr) begin
        rdata <= {5'h00, ptr_q};
      end
      iocs16_n  <= !(mode_16bit && io_sel &&
                     (is_ptr || (is_data)));
      memcs16_n <= !(mode_16bit && mem_sel && !mode_io);
    end
  end

  // Multi-step checks: request taken, then the queue head reaches the RAM
  sequence s_mem_word_push;
    mem_req && !mode_io && mode_16bit && f_valid && f_ready;
  endsequence
  sequence s_rd_taken;
    hit && !wr_en && f_valid && f_ready && mode_16bit;
  endsequence

  chk_strobe_8bit: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    !$past(mode_16bit) |-> iocs16_n && memcs16_n && hi_oe_n)
    else $error("16-bit strobe or upper lane in 8-bit mode");
  chk_io16_other: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    $past(io_sel && !is_ptr && !is_data) |-> iocs16_n)
    else $error("16-bit strobe on 8-bit register");
  chk_io16_data: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (mode_16bit && io_sel && is_data) |=> !iocs16_n)
    else $error("16-bit strobe missing on data register");
  chk_ptr_hold: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (is_ptr && wr_en && io_offset == hbas_pkg::OFS_PTR_HI &&
     !(mode_16bit && lo_b)) |=> $stable(ptr_q))
    else $error("pointer changed on high byte write");
  chk_ptr_bump: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (bump && f_valid && f_ready && !is_ptr) |=>
      ptr_q == $past(ptr_q) + hbas_pkg::PTR_STEP)
    else $error("pointer did not advance");
  chk_no_bump: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (is_data && mode_16bit && !hi_b) |=> $stable(ptr_q))
    else $error("even byte access advanced pointer");
  // Queue adds two cycles, the RAM port register one more
  chk_mem_addr: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    s_mem_word_push ##2 o_valid |=>
      ram_addr == {1'b0, $past(bus_addr[10:1], 3)})
    else $error("memory mode word address wrong");
  chk_read_lanes: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    s_rd_taken |-> ##4 (rdata_valid && lo_oe_n == $past(bus_addr[0], 4) &&
      hi_oe_n == $past(sbhe_n, 4)))
    else $error("read lane enable mismatch");
  chk_data_port: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (io_req && mode_io && wr_en && f_ready &&
     io_offset == hbas_pkg::OFS_DATA_LO) |->
      ##3 (ram_we && ram_addr == $past(ptr_q, 3)))
    else $error("data register write did not reach the buffer");
endmodule : hbas_top

// >>> testbench/hbas_host.sv
// Host processor model issuing single-cycle bus requests
module hbas_host (
  // Clock and strobes seen
  input  wire logic        clk_sys,
  input  wire logic        iocs16_n,
  input  wire logic        memcs16_n,
  // Request
  output logic             io_req,
  output logic             mem_req,
  output logic             wr_en,
  output logic [3:0]       io_offset,
  output logic [10:0]      bus_addr,
  output logic             sbhe_n,
  output logic [15:0]      wdata,
  output logic             io_sel,
  output logic             mem_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cs_seen;
  initial begin
    {io_req, mem_req, wr_en, io_sel, mem_sel, sbhe_n} = 6'h01;
    {io_offset, bus_addr, wdata} = '0;
    cs_seen = 2'h3;
  end
  // Callers issue only defined lane mixes, pointer high before low
  task automatic cyc(input logic io, input logic wr, input logic [3:0] off,
                     input logic [10:0] a, input logic sb,
                     input logic [15:0] d);
    @(negedge clk_sys);
    {io_req, io_sel, mem_req, mem_sel} = {io, io, !io, !io};
    {wr_en, io_offset, bus_addr, sbhe_n, wdata} = {wr, off, a, sb, d};
    @(negedge clk_sys);
    cs_seen = {iocs16_n, memcs16_n};
    {io_req, io_sel, mem_req, mem_sel} = 4'h0;
    // Released bus must not keep showing the old data
    wdata = ~d;
  endtask : cyc
endmodule : hbas_host

// >>> testbench/tb.sv
// Self-checking testbench for host buffer access steering
module tb;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
  logic        clk_sys = 0, reset_n = 0, mode_16bit = 1, mode_io = 1;
  logic        auto_inc = 1, io_req, mem_req, wr_en, sbhe_n, io_sel;
  logic        mem_sel, rdata_valid, lo_oe_n, hi_oe_n, iocs16_n;
  logic        memcs16_n, busy, ram_we, ram_re;
  logic [3:0]  io_offset;
  logic [10:0] bus_addr, ram_addr;
  logic [15:0] wdata, rdata, ram_wdata, ram_rdata;
  logic [1:0]  ram_be;
  logic [15:0] mem [0:2047];
  int          failures = 0, checks = 0;
  always #12.5 clk_sys = ~clk_sys;
  // Data only valid in the read cycle; otherwise a changed pattern
  assign ram_rdata = ram_re ? mem[ram_addr] : ~mem[ram_addr];
  always @(posedge clk_sys) begin
    if (ram_we && ram_be[0]) mem[ram_addr][7:0] <= ram_wdata[7:0];
    if (ram_we && ram_be[1]) mem[ram_addr][15:8] <= ram_wdata[15:8];
  end
  hbas_top hbas_top_i (.clk_sys(clk_sys), .reset_n(reset_n),
    .mode_16bit(mode_16bit), .mode_io(mode_io), .auto_inc(auto_inc),
    .io_req(io_req), .mem_req(mem_req), .wr_en(wr_en),
    .io_offset(io_offset), .bus_addr(bus_addr), .sbhe_n(sbhe_n),
    .wdata(wdata), .io_sel(io_sel), .mem_sel(mem_sel), .rdata(rdata),
    .rdata_valid(rdata_valid), .lo_oe_n(lo_oe_n), .hi_oe_n(hi_oe_n),
    .iocs16_n(iocs16_n), .memcs16_n(memcs16_n), .busy(busy),
    .ram_we(ram_we), .ram_re(ram_re), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .ram_be(ram_be), .ram_rdata(ram_rdata));
  hbas_host hbas_host_i (.clk_sys(clk_sys), .iocs16_n(iocs16_n),
    .memcs16_n(memcs16_n), .io_req(io_req), .mem_req(mem_req),
    .wr_en(wr_en), .io_offset(io_offset), .bus_addr(bus_addr),
    .sbhe_n(sbhe_n), .wdata(wdata), .io_sel(io_sel), .mem_sel(mem_sel));
  task automatic rst(input logic m16, input logic mio);
    @(negedge clk_sys);
    {reset_n, mode_16bit, mode_io} = {1'b0, m16, mio};
    repeat (5) @(negedge clk_sys);
    reset_n = 1;
  endtask : rst
  task automatic exp_wr(input logic [10:0] a, input logic [1:0] be,
                        input logic [15:0] d);
    for (int i = 0; i < 8 && !ram_we; i++) @(negedge clk_sys);
    `CHK(ram_we, 1'b1)
    `CHK({ram_re, busy}, 2'b00)
    `CHK({ram_addr, ram_be}, {a, be})
    `CHK(ram_wdata & {{8{be[1]}}, {8{be[0]}}}, d)
  endtask : exp_wr
  task automatic exp_rd(input logic [15:0] d, input logic [15:0] m,
                        input logic [1:0] oe);
    for (int i = 0; i < 8 && !rdata_valid; i++) @(negedge clk_sys);
    `CHK(rdata_valid, 1'b1)
    `CHK({rdata & m, hi_oe_n, lo_oe_n}, {d, oe})
  endtask : exp_rd
  task automatic t_io16;
    rst(1'b1, 1'b1);
    hbas_host_i.cyc(1, 1, 4'hA, 11'h000, 0, 16'h0110);
    `CHK(hbas_host_i.cs_seen, 2'b01)
    hbas_host_i.cyc(1, 1, 4'hC, 11'h000, 0, 16'h1234);
    exp_wr(11'h110, 2'b11, 16'h1234);
    hbas_host_i.cyc(1, 1, 4'hB, 11'h001, 0, 16'h0500);
    hbas_host_i.cyc(1, 1, 4'hC, 11'h000, 0, 16'h5678);
    exp_wr(11'h111, 2'b11, 16'h5678);
    hbas_host_i.cyc(1, 1, 4'hA, 11'h000, 1, 16'h003C);
    hbas_host_i.cyc(1, 1, 4'hC, 11'h000, 1, 16'h00AB);
    exp_wr(11'h53C, 2'b01, 16'h00AB);
    hbas_host_i.cyc(1, 1, 4'hD, 11'h001, 0, 16'hCD00);
    exp_wr(11'h53C, 2'b10, 16'hCD00);
    hbas_host_i.cyc(1, 1, 4'hA, 11'h000, 1, 16'h003C);
    hbas_host_i.cyc(1, 0, 4'hA, 11'h000, 1, 16'h0000);
    `CHK(rdata, 16'h053C)
    hbas_host_i.cyc(1, 0, 4'hC, 11'h000, 0, 16'h0000);
    exp_rd(16'hCDAB, 16'hFFFF, 2'b00);
    hbas_host_i.cyc(1, 0, 4'hC, 11'h000, 0, 16'h0000);
    exp_rd(16'h053D, 16'hFFFF, 2'b00);
    hbas_host_i.cyc(1, 1, 4'h0, 11'h000, 1, 16'h0000);
    `CHK(hbas_host_i.cs_seen, 2'b11)
  endtask : t_io16
  task automatic t_mem16;
    rst(1'b1, 1'b0);
    hbas_host_i.cyc(0, 1, 4'h0, 11'h2A6, 0, 16'hBEEF);
    `CHK(hbas_host_i.cs_seen, 2'b10)
    exp_wr(11'h153, 2'b11, 16'hBEEF);
    hbas_host_i.cyc(0, 1, 4'h0, 11'h2A6, 1, 16'h0011);
    exp_wr(11'h153, 2'b01, 16'h0011);
    hbas_host_i.cyc(0, 1, 4'h0, 11'h2A7, 0, 16'h2200);
    exp_wr(11'h153, 2'b10, 16'h2200);
    hbas_host_i.cyc(0, 0, 4'h0, 11'h2A6, 0, 16'h0000);
    exp_rd(16'h2211, 16'hFFFF, 2'b00);
  endtask : t_mem16
  task automatic t_io8;
    rst(1'b0, 1'b1);
    hbas_host_i.cyc(1, 1, 4'hB, 11'h001, 1, 16'h0002);
    `CHK(hbas_host_i.cs_seen, 2'b11)
    hbas_host_i.cyc(1, 1, 4'hA, 11'h000, 1, 16'h0034);
    hbas_host_i.cyc(1, 0, 4'hC, 11'h000, 1, 16'h0000);
    exp_rd(16'h0034, 16'h00FF, 2'b10);
    hbas_host_i.cyc(1, 0, 4'hC, 11'h000, 1, 16'h0000);
    exp_rd(16'h0035, 16'h00FF, 2'b10);
    hbas_host_i.cyc(1, 1, 4'hC, 11'h000, 1, 16'hAA55);
    exp_wr(11'h236, 2'b01, 16'h0055);
  endtask : t_io8
  task automatic end_of_test;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    for (int i = 0; i < 2048; i++) mem[i] = 16'(i);
    t_io16();
    t_mem16();
    t_io8();
    end_of_test();
  end
  // About 25 times the expected run
  initial begin
    #(25 * 2000);
    failures++;
    end_of_test();
  end
endmodule : tb
